// ### logic/spienc_params.svh
// Register indices, field positions, reset values of the encoder poller
`ifndef SPIENC_PARAMS_SVH
`define SPIENC_PARAMS_SVH

// --------------------------------------------------------------
// Register indices (byte address is four times the index)
// --------------------------------------------------------------
`define SPIENC_IDX_CONF   8'h07
`define SPIENC_IDX_FMT    8'h08
`define SPIENC_IDX_PHASE  8'h56
`define SPIENC_IDX_DELAY  8'h57
`define SPIENC_IDX_PAUSE  8'h58
`define SPIENC_IDX_ADDR   8'h68
`define SPIENC_IDX_DATA   8'h69
`define SPIENC_IDX_AREPLY 8'h6A
`define SPIENC_IDX_DREPLY 8'h6B

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define SPIENC_CONF_MODE_MSB 1
`define SPIENC_CONF_MODE_LSB 0
`define SPIENC_CONF_GRAY     2
`define SPIENC_CONF_MTEN     3
`define SPIENC_CONF_LEFT     4
`define SPIENC_CONF_CSAFTER  5
`define SPIENC_CONF_DATACS   6
`define SPIENC_MODE_SPI      2'h3
`define SPIENC_FMT_ST_MSB    4
`define SPIENC_FMT_ST_LSB    0
`define SPIENC_FMT_MT_MSB    9
`define SPIENC_FMT_MT_LSB    5
`define SPIENC_FMT_SC_MSB    11
`define SPIENC_FMT_SC_LSB    10
`define SPIENC_FMT_AB_MSB    17
`define SPIENC_FMT_AB_LSB    12
`define SPIENC_FMT_DB_MSB    23
`define SPIENC_FMT_DB_LSB    18
`define SPIENC_PH_LOW_MSB    15
`define SPIENC_PH_LOW_LSB    0
`define SPIENC_PH_HIGH_MSB   31
`define SPIENC_PH_HIGH_LSB   16
`define SPIENC_DLY_MSB       15

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define SPIENC_RST_CONF  32'h0000_0000
`define SPIENC_RST_FMT   32'h0040_800F
`define SPIENC_RST_PHASE 32'h0005_0005
`define SPIENC_RST_DELAY 32'h0000_0000
`define SPIENC_RST_PAUSE 32'h0000_0100
`define SPIENC_RST_WORD  32'h0000_0000

`endif

// ### logic/spienc_pkg.sv
// Types of the encoder poller
`default_nettype none
package spienc_pkg;
    // Serial engine states, Gray along the frame path
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_LEAD  = 3'h1,
        S_LOW   = 3'h3,
        S_HIGH  = 3'h2,
        S_TRAIL = 3'h6,
        S_PAUSE = 3'h7
    } spienc_state_t;
    // Polling / configuration handshake phases
    typedef enum logic [2:0] {
        CP_POLL = 3'h0,
        CP_HALT = 3'h1,
        CP_ADDR = 3'h3,
        CP_DATA = 3'h2,
        CP_NOP  = 3'h6,
        CP_DONE = 3'h7
    } spienc_phase_t;
endpackage
`default_nettype wire

// ### logic/spienc_master.sv
// SPI absolute encoder poller with APB register file
//
// Contract
// - Gray enable set: angle bits decoded from Gray to binary.
// - Poll length comes from format fields alone, not multiturn enable.
// - Poll request word is outgoing address, bit 0 sent last.
// - Poll reply stored in address reply, position recomputed.
// - Serial clock high and low phases programmed separately.
// - Programmed pause between end of request and next request.
// - Mode field 11 runs SPI polling with clock bursts.
// - Negated clock pin is active-low chip select.
// - Negated data pin is MOSI carrying request datagrams.
// - Select-first setting picks select before or after clock.
// - Data-on-select setting picks when first bit appears.
// - Default select-to-clock gap is current clock phase length.
// - Delay register overrides first and last select gaps.
// - Configuration sends address datagram then data datagram.
// - First data write halts polling after current transfer.
// - Second data write: address datagram, reply discarded.
// - Data datagram sent, reply stored as address reply.
// - NOP datagram sent, reply stored as data reply.
// - Polling resumes only after data reply register read.
// - Poll clocks: angle width+1 plus turns width+1 plus status.
// - Multiturn disabled: turns part dropped from position.
`include "spienc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module spienc_master #(
    parameter int TW = 24
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Encoder link
    output logic             serialClock,
    output logic             negatedClockPinN,
    output logic             negatedDataPin,
    input  wire logic        serialDataIn,
    // Position result
    output logic      [31:0] encPosition,
    output logic             posUpdate
);

    // --------------------------------------------------------------
    // Elaboration check
    // --------------------------------------------------------------
    if (TW < 16 || TW > 32) begin : g_chk
        $error("TW must lie in 16..32");
    end

    // --------------------------------------------------------------
    // Functions
    // --------------------------------------------------------------
    function automatic logic [31:0] byteMerge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
        for (int i = 0; i < 4; i++)
        begin
            old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        return old;
    endfunction

    function automatic logic [TW-1:0] durm1(input logic [TW-1:0] d);
        return (d == '0) ? '0 : d - TW'(1);
    endfunction

    function automatic logic txBit(input logic [31:0] w, input logic [6:0] n);
        if (n == 7'h00 || n > 7'h20)
            return 1'b0;
        return w[5'(n - 7'h01)];
    endfunction

    function automatic logic [31:0] lowMask(input logic [5:0] n);
        return (n >= 6'h20) ? 32'hFFFF_FFFF : ((32'h1 << n) - 32'h1);
    endfunction

    function automatic logic [31:0] grayToBin(input logic [31:0] g);
        logic [31:0] b;
        b = g;
        for (int i = 30; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [31:0] conf_reg, fmt_reg, phase_reg, delay_reg, pause_reg;
    logic [31:0] addr_reg, data_reg, aReply_reg, dReply_reg;
    logic [31:0] rx_reg, rx_next, tx_reg, tx_next;
    logic [TW-1:0] timer_reg, timer_next;
    logic [6:0]  bits_reg, bits_next;
    logic        sclk_reg, sclk_next, cs_reg, cs_next, mosi_reg, mosi_next;
    logic        misoMeta_reg, misoSync_reg;
    logic        frameDone;
    spienc_pkg::spienc_state_t state_reg, state_next;
    spienc_pkg::spienc_phase_t phase_st_reg, phase_st_next, kind_reg, kind_next;

    // --------------------------------------------------------------
    // APB decode
    // --------------------------------------------------------------
    wire [7:0] regIdx  = paddr[9:2];
    wire       addrOk  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    wire       selConf = addrOk && regIdx == `SPIENC_IDX_CONF;
    wire       selFmt  = addrOk && regIdx == `SPIENC_IDX_FMT;
    wire       selPh   = addrOk && regIdx == `SPIENC_IDX_PHASE;
    wire       selDly  = addrOk && regIdx == `SPIENC_IDX_DELAY;
    wire       selPau  = addrOk && regIdx == `SPIENC_IDX_PAUSE;
    wire       selAddr = addrOk && regIdx == `SPIENC_IDX_ADDR;
    wire       selData = addrOk && regIdx == `SPIENC_IDX_DATA;
    wire       selArep = addrOk && regIdx == `SPIENC_IDX_AREPLY;
    wire       selDrep = addrOk && regIdx == `SPIENC_IDX_DREPLY;
    wire       mapped  = selConf | selFmt | selPh | selDly | selPau
                       | selAddr | selData | selArep | selDrep;
    wire       access  = psel & penable;
    wire       wrEn    = access & pwrite & mapped;
    wire       rdDrep  = access & ~pwrite & selDrep;
    wire       wrData  = wrEn & selData;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = !(psel && !pwrite) ? 32'h0 :
                     selConf ? conf_reg   : selFmt  ? fmt_reg    :
                     selPh   ? phase_reg  : selDly  ? delay_reg  :
                     selPau  ? pause_reg  : selAddr ? addr_reg   :
                     selData ? data_reg   : selArep ? aReply_reg :
                     selDrep ? dReply_reg : 32'h0;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            conf_reg  <= `SPIENC_RST_CONF;
            fmt_reg   <= `SPIENC_RST_FMT;
            phase_reg <= `SPIENC_RST_PHASE;
            delay_reg <= `SPIENC_RST_DELAY;
            pause_reg <= `SPIENC_RST_PAUSE;
            addr_reg  <= `SPIENC_RST_WORD;
            data_reg  <= `SPIENC_RST_WORD;
        end
        else if (wrEn)
        begin
            if (selConf) conf_reg  <= byteMerge(conf_reg, pwdata, pstrb);
            if (selFmt)  fmt_reg   <= byteMerge(fmt_reg, pwdata, pstrb);
            if (selPh)   phase_reg <= byteMerge(phase_reg, pwdata, pstrb);
            if (selDly)  delay_reg <= byteMerge(delay_reg, pwdata, pstrb);
            if (selPau)  pause_reg <= byteMerge(pause_reg, pwdata, pstrb);
            if (selAddr) addr_reg  <= byteMerge(addr_reg, pwdata, pstrb);
            if (selData) data_reg  <= byteMerge(data_reg, pwdata, pstrb);
        end
    end

    // --------------------------------------------------------------
    // Configuration fields
    // --------------------------------------------------------------
    wire [1:0] encMode     = conf_reg[`SPIENC_CONF_MODE_MSB:`SPIENC_CONF_MODE_LSB];
    wire       grayEn      = conf_reg[`SPIENC_CONF_GRAY];
    wire       multiTurnEn = conf_reg[`SPIENC_CONF_MTEN];
    wire       leftAligned = conf_reg[`SPIENC_CONF_LEFT];
    wire       csAfterClk  = conf_reg[`SPIENC_CONF_CSAFTER];
    wire       dataOnCs    = conf_reg[`SPIENC_CONF_DATACS];
    wire [4:0] angleWidthField     = fmt_reg[`SPIENC_FMT_ST_MSB:`SPIENC_FMT_ST_LSB];
    wire [4:0] revolutionWidthField = fmt_reg[`SPIENC_FMT_MT_MSB:`SPIENC_FMT_MT_LSB];
    wire [1:0] statusBitCount = fmt_reg[`SPIENC_FMT_SC_MSB:`SPIENC_FMT_SC_LSB];
    wire [5:0] addrBits    = fmt_reg[`SPIENC_FMT_AB_MSB:`SPIENC_FMT_AB_LSB];
    wire [5:0] dataBits    = fmt_reg[`SPIENC_FMT_DB_MSB:`SPIENC_FMT_DB_LSB];
    wire [TW-1:0] lowDur   = TW'(phase_reg[`SPIENC_PH_LOW_MSB:`SPIENC_PH_LOW_LSB]);
    wire [TW-1:0] highDur  = TW'(phase_reg[`SPIENC_PH_HIGH_MSB:`SPIENC_PH_HIGH_LSB]);
    wire [TW-1:0] dlyDur   = TW'(delay_reg[`SPIENC_DLY_MSB:0]);
    wire [TW-1:0] pauseDur = pause_reg[TW-1:0];

    // --------------------------------------------------------------
    // Frame selection
    // --------------------------------------------------------------
    // poll clock count
    wire [6:0] pollBits = {2'h0, angleWidthField} + 7'h01
                        + {2'h0, revolutionWidthField} + 7'h01
                        + {5'h00, statusBitCount};
    wire cfgBusy = phase_st_reg == spienc_pkg::CP_ADDR
                || phase_st_reg == spienc_pkg::CP_DATA
                || phase_st_reg == spienc_pkg::CP_NOP;
    // polling only in SPI mode, halted outside poll phase
    wire startPoll = encMode == `SPIENC_MODE_SPI && phase_st_reg == spienc_pkg::CP_POLL;
    wire startFrame = state_reg == spienc_pkg::S_IDLE && (startPoll || cfgBusy);
    // address datagram width, then data width for data and NOP
    wire [6:0] cfgBits = (phase_st_reg == spienc_pkg::CP_ADDR) ? {1'b0, addrBits}
                                                              : {1'b0, dataBits};
    wire [6:0] rawBits = cfgBusy ? cfgBits : pollBits;
    wire [6:0] nBitsSel = (rawBits == 7'h00) ? 7'h01 : rawBits;
    // poll word, address datagram, data, NOP
    wire [31:0] txSel = (phase_st_reg == spienc_pkg::CP_DATA) ? data_reg :
                        (phase_st_reg == spienc_pkg::CP_NOP)  ? 32'h0    : addr_reg;
    // first bit at start when the first slope or select comes first
    wire firstAtStart = dataOnCs ^ csAfterClk;
    // default gap from current phase, delay override
    wire [TW-1:0] leadDur  = (dlyDur != '0) ? dlyDur : (csAfterClk ? lowDur : highDur);
    wire [TW-1:0] trailDur = (dlyDur != '0) ? dlyDur : highDur;
    wire timerZero = timer_reg == '0;

    // --------------------------------------------------------------
    // Serial engine
    // --------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        timer_next = timerZero ? timer_reg : timer_reg - TW'(1);
        sclk_next  = sclk_reg;
        cs_next    = cs_reg;
        mosi_next  = mosi_reg;
        bits_next  = bits_reg;
        rx_next    = rx_reg;
        tx_next    = tx_reg;
        kind_next  = kind_reg;
        frameDone  = 1'b0;
        unique case (state_reg)
            spienc_pkg::S_IDLE:
                if (startFrame)
                begin
                    state_next = spienc_pkg::S_LEAD;
                    timer_next = durm1(leadDur);
                    kind_next  = phase_st_reg;
                    tx_next    = txSel;
                    bits_next  = nBitsSel;
                    // select before or after the first clock slope
                    if (csAfterClk)
                        sclk_next = 1'b0;
                    else
                        cs_next = 1'b0;
                    if (firstAtStart)
                        mosi_next = txBit(txSel, nBitsSel);
                end
            spienc_pkg::S_LEAD:
                if (timerZero)
                begin
                    state_next = spienc_pkg::S_LOW;
                    timer_next = durm1(lowDur);
                    sclk_next  = 1'b0;
                    cs_next    = 1'b0;
                    if (!firstAtStart)
                        mosi_next = txBit(tx_reg, bits_reg);
                end
            spienc_pkg::S_LOW:
                // low phase ends, sample on rising slope
                if (timerZero)
                begin
                    state_next = spienc_pkg::S_HIGH;
                    timer_next = durm1(highDur);
                    sclk_next  = 1'b1;
                    rx_next    = {rx_reg[30:0], misoSync_reg};
                end
            spienc_pkg::S_HIGH:
                if (timerZero)
                begin
                    if (bits_reg == 7'h01)
                    begin
                        state_next = spienc_pkg::S_TRAIL;
                        timer_next = durm1(trailDur);
                    end
                    else
                    begin
                        // next lower bit on each falling slope
                        state_next = spienc_pkg::S_LOW;
                        timer_next = durm1(lowDur);
                        sclk_next  = 1'b0;
                        bits_next  = bits_reg - 7'h01;
                        mosi_next  = txBit(tx_reg, bits_reg - 7'h01);
                    end
                end
            spienc_pkg::S_TRAIL:
                if (timerZero)
                begin
                    state_next = spienc_pkg::S_PAUSE;
                    timer_next = durm1(pauseDur);
                    cs_next    = 1'b1;
                    mosi_next  = 1'b0;
                    frameDone  = 1'b1;
                end
            spienc_pkg::S_PAUSE:
                if (timerZero)
                    state_next = spienc_pkg::S_IDLE;
            default:
                state_next = spienc_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= spienc_pkg::S_IDLE;
            kind_reg  <= spienc_pkg::CP_POLL;
            timer_reg <= '0;
            bits_reg  <= 7'h00;
            sclk_reg  <= 1'b1;
            cs_reg    <= 1'b1;
            mosi_reg  <= 1'b0;
            rx_reg    <= 32'h0;
            tx_reg    <= 32'h0;
        end
        else
        begin
            state_reg <= state_next;
            kind_reg  <= kind_next;
            timer_reg <= timer_next;
            bits_reg  <= bits_next;
            sclk_reg  <= sclk_next;
            cs_reg    <= cs_next;
            mosi_reg  <= mosi_next;
            rx_reg    <= rx_next;
            tx_reg    <= tx_next;
        end
    end

    // Input synchroniser for the reply line
    always_ff @(posedge clk)
    begin
        misoMeta_reg <= serialDataIn;
        misoSync_reg <= misoMeta_reg;
    end

    assign serialClock      = sclk_reg;
    assign negatedClockPinN = cs_reg;
    assign negatedDataPin   = mosi_reg;

    // --------------------------------------------------------------
    // Configuration handshake
    // --------------------------------------------------------------
    always_comb
    begin
        phase_st_next = phase_st_reg;
        unique case (phase_st_reg)
            spienc_pkg::CP_POLL: if (wrData) phase_st_next = spienc_pkg::CP_HALT;
            // second data write launches the sequence
            spienc_pkg::CP_HALT: if (wrData) phase_st_next = spienc_pkg::CP_ADDR;
            spienc_pkg::CP_ADDR, spienc_pkg::CP_DATA, spienc_pkg::CP_NOP:
                if (frameDone && kind_reg == phase_st_reg)
                    phase_st_next = (phase_st_reg == spienc_pkg::CP_ADDR) ? spienc_pkg::CP_DATA :
                                    (phase_st_reg == spienc_pkg::CP_DATA) ? spienc_pkg::CP_NOP
                                                                          : spienc_pkg::CP_DONE;
            spienc_pkg::CP_DONE: if (rdDrep) phase_st_next = spienc_pkg::CP_POLL;
            default: phase_st_next = spienc_pkg::CP_POLL;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            phase_st_reg <= spienc_pkg::CP_POLL;
        else
            phase_st_reg <= phase_st_next;
    end

    // --------------------------------------------------------------
    // Reply capture and position
    // --------------------------------------------------------------
    // status bits removed unless left-aligned, turns dropped when disabled
    wire [31:0] dataPart  = leftAligned ? rx_reg : rx_reg >> statusBitCount;
    wire [5:0]  angleBits = {1'b0, angleWidthField} + 6'h01;
    wire [31:0] angleRaw  = dataPart & lowMask(angleBits);
    wire [31:0] angleVal  = grayEn ? grayToBin(angleRaw) : angleRaw;
    wire [31:0] revVal    = (dataPart >> angleBits)
                          & lowMask({1'b0, revolutionWidthField} + 6'h01);
    wire [31:0] posNext   = multiTurnEn ? ((revVal << angleBits) | angleVal) : angleVal;
    wire pollDone = frameDone && kind_reg == spienc_pkg::CP_POLL;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            aReply_reg  <= `SPIENC_RST_WORD;
            dReply_reg  <= `SPIENC_RST_WORD;
            encPosition <= 32'h0;
            posUpdate   <= 1'b0;
        end
        else
        begin
            if (pollDone || (frameDone && kind_reg == spienc_pkg::CP_DATA))
                aReply_reg <= rx_reg;
            if (frameDone && kind_reg == spienc_pkg::CP_NOP)
                dReply_reg <= rx_reg;
            if (pollDone)
                encPosition <= posNext;
            posUpdate <= pollDone;
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_cs_idle_high: assert property (
        state_reg == spienc_pkg::S_IDLE |-> negatedClockPinN && serialClock)
        else $error("select active while idle");
    a_lead_order: assert property (
        state_reg == spienc_pkg::S_LEAD |-> (csAfterClk ? (negatedClockPinN && !serialClock)
                                                      : (!negatedClockPinN && serialClock)))
        else $error("select and clock out of order");
    a_low_hold: assert property (
        state_reg == spienc_pkg::S_LOW && !timerZero |=> state_reg == spienc_pkg::S_LOW && !serialClock)
        else $error("low phase cut short");
    a_lsb_last: assert property (
        state_reg == spienc_pkg::S_HIGH && bits_reg == 7'h01 |-> negatedDataPin == tx_reg[0])
        else $error("last bit is not bit 0");
    a_pause_hold: assert property (
        state_reg == spienc_pkg::S_PAUSE && !timerZero |=> state_reg == spienc_pkg::S_PAUSE)
        else $error("pause cut short");
    a_halt_idle: assert property (
        state_reg == spienc_pkg::S_IDLE && phase_st_reg == spienc_pkg::CP_HALT |=> state_reg == spienc_pkg::S_IDLE)
        else $error("frame started while halted");
    a_poll_store: assert property (
        pollDone |=> aReply_reg == $past(rx_reg) && posUpdate)
        else $error("poll reply not stored");
    a_nop_store: assert property (
        frameDone && kind_reg == spienc_pkg::CP_NOP |=> dReply_reg == $past(rx_reg)
                                                      && phase_st_reg == spienc_pkg::CP_DONE)
        else $error("data reply not stored");
    a_resume_read: assert property (
        phase_st_reg == spienc_pkg::CP_DONE && !rdDrep |=> phase_st_reg == spienc_pkg::CP_DONE)
        else $error("polling resumed without read");

endmodule
`default_nettype wire

// ### testbench/spienc_enc_model.sv
// Behavioural SPI encoder on the far side of the poller
`timescale 1ns/1ps
`default_nettype none
module spienc_enc_model #(
    parameter int NB = 5
) (
    input  wire logic sclk,
    input  wire logic csN,
    input  wire logic mosi,
    output logic      miso
);
    logic [31:0] rxW = 32'h0;
    logic [31:0] txW = 32'h0;
    logic        idleV = 1'b0;
    always @(posedge csN)
    begin
        txW <= rxW;
        idleV <= ~txW[NB-1];
    end
    always @(posedge sclk)
    begin
        if (!csN) rxW <= {rxW[30:0], mosi};
        if (!csN) txW <= {txW[30:0], 1'b0};
    end
    assign miso = csN ? idleV : txW[NB-1];
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Register and link tests of the encoder poller
`include "spienc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, encPosition, rd;
    logic        pready, pslverr, serialClock, csN, mosi, miso, posUpdate, er;
    int          errors = 0, tests_run = 0, csRise = 0, sclkCnt = 0, base, n;
    logic [31:0] cv[3] = '{32'h3, 32'hB, 32'h7};
    logic [31:0] pv[3] = '{32'h6, 32'h16, 32'h4};
    always #5 clk = ~clk;
    always @(posedge csN) csRise++;
    always @(negedge csN) sclkCnt = 0;
    always @(posedge serialClock) if (!csN) sclkCnt++;
    spienc_master dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serialClock(serialClock),
        .negatedClockPinN(csN), .negatedDataPin(mosi), .serialDataIn(miso),
        .encPosition(encPosition), .posUpdate(posUpdate));
    spienc_enc_model #(.NB(5)) enc_u (.sclk(serialClock), .csN(csN), .mosi(mosi), .miso(miso));
    task automatic print_verdict;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50)
        begin
            check(32'h1, 32'h0);
            print_verdict;
        end
    endtask
    task automatic waitPos;
        for (n = 0; n < 9000 && posUpdate !== 1'b1; n++) @(posedge clk);
        check(n < 9000, 32'h1);
        if (n >= 9000) print_verdict;
        @(posedge clk);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        apb(0, `SPIENC_IDX_FMT, 0); check(rd, `SPIENC_RST_FMT);
        apb(0, `SPIENC_IDX_PHASE, 0); check(rd, `SPIENC_RST_PHASE);
        apb(0, `SPIENC_IDX_PAUSE, 0); check(rd, `SPIENC_RST_PAUSE);
        apb(0, 8'h09, 0); check({rd[30:0], er}, 32'h1);
        apb(1, `SPIENC_IDX_FMT, 32'h0014_5003);
        apb(1, `SPIENC_IDX_ADDR, 32'h16);
        for (int i = 0; i < 3; i++)
        begin
            apb(1, `SPIENC_IDX_CONF, cv[i]);
            waitPos;
            waitPos;
            check(encPosition, pv[i]);
            check(sclkCnt, 32'h5);
            apb(0, `SPIENC_IDX_AREPLY, 0); check(rd & 32'h1F, 32'h16);
            $display("poll test %0d done", i);
        end
        // Clock first, data on select, programmed select gap
        apb(1, `SPIENC_IDX_DELAY, 32'h3);
        apb(1, `SPIENC_IDX_CONF, 32'h63);
        waitPos;
        waitPos;
        check(encPosition, 32'h6);
        check(sclkCnt, 32'h5);
        $display("clock-first test done");
        apb(1, `SPIENC_IDX_DATA, 32'h0);
        repeat (2) @(posedge clk);
        for (n = 0; n < 900 && csN !== 1'b1; n++) @(posedge clk);
        check(csN, 1'b1);
        base = csRise;
        apb(1, `SPIENC_IDX_ADDR, 32'h0A);
        apb(1, `SPIENC_IDX_DATA, 32'h13);
        for (n = 0; n < 9000 && csRise < base + 3; n++) @(posedge clk);
        repeat (600) @(posedge clk);
        check(csRise, base + 3);
        apb(0, `SPIENC_IDX_AREPLY, 0); check(rd & 32'h1F, 32'h0A);
        apb(1, `SPIENC_IDX_ADDR, 32'h16);
        apb(0, `SPIENC_IDX_DREPLY, 0); check(rd & 32'h1F, 32'h13);
        waitPos;
        $display("config test done");
        print_verdict;
    end
endmodule
`default_nettype wire
